/* ism_top.sv */
// interrupt status, mask and request logic with apb register access
//
// Implementation choices: the APB slave port and the register offsets.
`default_nettype none
// Behaviour
// - five direct sources; bit 0 sums eight extended
// - primary read keeps only summary and code-change flags
// - code-change flag cleared only by channel-0 code read
// - extended read clears it and the summary flag
// - request released when primary status is clear
// - masked flags hidden, pending, untouched by reads
// - summary and code-change flags set when masked, no request
// - change from sq, channel 0, or channel 1 in second-gen terminal
// - sq or channel-1 change hidden while enable is zero
// - channel-0 code read clears enabled channels' change bits, or loads a pending code
// - two-deep code registers; latest replaces pending
// - monitor flags in second-gen mode only; one channel
// - rx flags gated by rx enables; ack and abort by tx enable
// - rx enable off none; no handshake control first byte; both every byte
// - first-gen: each monitor byte sets monitor status flag
// - level request, no gap while sources remain
// - all-ones mask releases; restore with pending reasserts
// - request changes only on data-clock rising edge
// - open-drain pin, pulled low while requesting
module ism_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic pclken,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic serial_data_clock,
    input wire logic second_gen_mode,
    input wire logic terminal_mode,
    input wire logic [4:0] direct_evt,
    input wire logic [7:0] ext_evt,
    input wire logic [3:0] sq_code_in,
    input wire logic [3:0] ch0_code_in,
    input wire logic [3:0] ch1_code_in,
    input wire logic tx_handshake_bit,
    input wire logic [7:0] monitor_data_in,
    input wire logic monitor_first_byte,
    input wire logic monitor_end_evt,
    input wire logic monitor_ack_evt,
    input wire logic monitor_abort_evt,
    output logic rx_handshake_bit,
    output logic irq_n_out,
    output logic irq_n_oe
);
    ism_pkg::ism_bus_e bus_r;
    logic [31:0] prdata_r;
    logic pslverr_r;
    logic [7:0] mask_r;
    logic [ism_pkg::NUM_DIRECT-1:0] direct_r;
    logic [ism_pkg::NUM_EXT-1:0] ext_r;
    logic mon_status_r;
    logic [3:0] mon_state_r;
    logic [7:0] mon_data_r;
    logic [1:0] sqtx_r;
    logic [2:0] mctl_r;
    logic rx_hs_r;
    logic tx_hs_q_r;
    logic dcl_q_r;
    logic irq_oe_r;
    logic [7:0] primary;
    logic [7:0] primary_vis;
    logic [7:0] rd_data;
    logic addr_ok;
    logic done;
    logic rd_done;
    logic wr_done;
    logic rd_primary;
    logic rd_ext;
    logic rd_ch0;
    logic rd_mon_state;
    logic rd_mon_data;
    logic dcl_rise;
    logic mon_byte;
    logic mon_gen2;
    logic [3:0] mon_set;
    logic [ism_pkg::NUM_CODE-1:0] code_chg;
    logic [ism_pkg::CODE_W-1:0] code_val [ism_pkg::NUM_CODE];
    logic [ism_pkg::CODE_W-1:0] code_src [ism_pkg::NUM_CODE];
    logic code_en [ism_pkg::NUM_CODE];

    ism_code_if cif [ism_pkg::NUM_CODE] ();

    // code sources and their change enables
    assign code_src[ism_pkg::CH_SQ] = sq_code_in;
    assign code_src[ism_pkg::CH_0] = ch0_code_in;
    assign code_src[ism_pkg::CH_1] = ch1_code_in;
    assign code_en[ism_pkg::CH_SQ] = sqtx_r[ism_pkg::SQTX_SQ_EN];
    assign code_en[ism_pkg::CH_0] = 1'b1;
    assign code_en[ism_pkg::CH_1] = sqtx_r[ism_pkg::SQTX_CH1_EN] & second_gen_mode & terminal_mode;

    // one two-deep buffer per received code, each enabled one cleared or advanced by the channel-0 read
    genvar gi;
    generate
        for (gi = 0; gi < ism_pkg::NUM_CODE; gi++)
        begin : g_code
            assign cif[gi].code_in = code_src[gi];
            assign cif[gi].enable = code_en[gi];
            assign cif[gi].rd = rd_ch0;
            assign code_val[gi] = cif[gi].code_out;
            assign code_chg[gi] = cif[gi].changed;
            ism_code_buf u_buf (
                .pclk(pclk),
                .presetn(presetn),
                .pclken(pclken),
                .cb(cif[gi])
            );
        end
    endgenerate

    // bus decode; answer comes in the second access cycle
    assign done = (bus_r == ism_pkg::ISM_DONE) & psel & penable;
    assign rd_done = done & ~pwrite & ~pslverr_r;
    assign wr_done = done & pwrite & ~pslverr_r;
    assign rd_primary = rd_done & (paddr[7:0] == ism_pkg::ADDR_PRIMARY);
    assign rd_ext = rd_done & (paddr[7:0] == ism_pkg::ADDR_EXTENDED);
    assign rd_ch0 = rd_done & (paddr[7:0] == ism_pkg::ADDR_CH0_CODE);
    assign rd_mon_state = rd_done & (paddr[7:0] == ism_pkg::ADDR_MON_STATE);
    assign rd_mon_data = rd_done & (paddr[7:0] == ism_pkg::ADDR_MON_DATA);

    // summary and code-change flags are live ORs, so a primary read cannot clear them
    always_comb
    begin
        primary = '0;
        primary[ism_pkg::PRI_EXT_SUMMARY] = |ext_r;
        primary[ism_pkg::PRI_MON_STATUS] = mon_status_r;
        primary[ism_pkg::PRI_CODE_CHANGE] = |code_chg;
        primary[7:ism_pkg::PRI_DIRECT_LSB] = direct_r;
    end
    assign primary_vis = primary & ~mask_r;

    // read mux, narrow data sits in the low byte
    always_comb
    begin
        addr_ok = 1'b1;
        rd_data = '0;
        case (paddr[7:0])
            ism_pkg::ADDR_PRIMARY: rd_data = primary_vis;
            ism_pkg::ADDR_MASK: rd_data = mask_r;
            ism_pkg::ADDR_EXTENDED: rd_data = ext_r;
            ism_pkg::ADDR_CH0_CODE: rd_data = {1'b0, code_chg[ism_pkg::CH_1], code_chg[ism_pkg::CH_0],
                code_chg[ism_pkg::CH_SQ], code_val[ism_pkg::CH_0]};
            ism_pkg::ADDR_CH1_CODE: rd_data = {4'h0, code_val[ism_pkg::CH_1]};
            ism_pkg::ADDR_SQ_CODE: rd_data = {4'h0, code_val[ism_pkg::CH_SQ]};
            ism_pkg::ADDR_SQ_TX: rd_data = {6'h00, sqtx_r};
            ism_pkg::ADDR_MON_CTRL: rd_data = {5'h00, mctl_r};
            ism_pkg::ADDR_MON_STATE: rd_data = {4'h0, mon_state_r};
            ism_pkg::ADDR_MON_DATA: rd_data = mon_data_r;
            default: addr_ok = 1'b0;
        endcase
        if (paddr[31:8] != 24'h000000)
        begin
            addr_ok = 1'b0;
        end
    end

    // apb handshake: wait one access cycle, then answer with pready
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            bus_r <= ism_pkg::ISM_IDLE;
            prdata_r <= '0;
            pslverr_r <= 1'b0;
        end
        else if (pclken)
        begin
            case (bus_r)
                ism_pkg::ISM_IDLE:
                    if (psel & penable)
                    begin
                        bus_r <= ism_pkg::ISM_DONE;
                        prdata_r <= {24'h000000, rd_data};
                        pslverr_r <= ~addr_ok;
                    end
                ism_pkg::ISM_DONE:
                    begin
                        bus_r <= ism_pkg::ISM_IDLE;
                        pslverr_r <= 1'b0;
                    end
                default: bus_r <= ism_pkg::ISM_IDLE;
            endcase
        end
    end
    assign prdata = prdata_r;
    assign pready = (bus_r == ism_pkg::ISM_DONE);
    assign pslverr = pslverr_r;

    // writable control registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mask_r <= ism_pkg::MASK_RESET;
            sqtx_r <= ism_pkg::SQTX_RESET;
            mctl_r <= ism_pkg::MCTL_RESET;
        end
        else if (pclken & wr_done)
        begin
            case (paddr[7:0])
                ism_pkg::ADDR_MASK: mask_r <= pwdata[7:0];
                ism_pkg::ADDR_SQ_TX: sqtx_r <= pwdata[1:0];
                ism_pkg::ADDR_MON_CTRL: mctl_r <= pwdata[2:0];
                default: mask_r <= mask_r;
            endcase
        end
    end

    // direct sources: only bits shown in the read data are cleared, so masked
    // bits and events arriving after the data was captured survive the read
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            direct_r <= '0;
        end
        else if (pclken)
        begin
            direct_r <= (direct_r & ~({ism_pkg::NUM_DIRECT{rd_primary}}
                & prdata_r[7:ism_pkg::PRI_DIRECT_LSB])) | direct_evt;
        end
    end

    // extended sources: a read clears what it returned, new events win
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ext_r <= '0;
        end
        else if (pclken)
        begin
            ext_r <= (ext_r & ~({ism_pkg::NUM_EXT{rd_ext}} & prdata_r[7:0])) | ext_evt;
        end
    end

    // monitor byte detection on a falling transmit handshake
    assign mon_byte = tx_hs_q_r & ~tx_handshake_bit;
    assign mon_gen2 = second_gen_mode;
    always_comb
    begin
        mon_set = '0;
        mon_set[ism_pkg::MST_DATA_RX] = mon_byte & mctl_r[ism_pkg::MCTL_RX_EN]
            & (mctl_r[ism_pkg::MCTL_HS_CTRL] | monitor_first_byte);
        mon_set[ism_pkg::MST_END_RX] = monitor_end_evt & mctl_r[ism_pkg::MCTL_RX_EN];
        mon_set[ism_pkg::MST_ACKED] = monitor_ack_evt & mctl_r[ism_pkg::MCTL_TX_EN];
        mon_set[ism_pkg::MST_ABORT] = monitor_abort_evt & mctl_r[ism_pkg::MCTL_TX_EN];
        if (!mon_gen2)
        begin
            mon_set = '0;
        end
    end

    // monitor state, stored data and receive handshake
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tx_hs_q_r <= 1'b1;
            mon_state_r <= '0;
            mon_data_r <= '0;
            rx_hs_r <= 1'b0;
        end
        else if (pclken)
        begin
            tx_hs_q_r <= tx_handshake_bit;
            mon_state_r <= (mon_state_r & ~({4{rd_mon_state}} & prdata_r[3:0])) | mon_set;
            if (mon_set[ism_pkg::MST_DATA_RX] | (mon_byte & ~mon_gen2))
            begin
                mon_data_r <= monitor_data_in;
            end
            // handshake only driven under handshake control in second-gen mode
            if (mon_gen2 & mctl_r[ism_pkg::MCTL_HS_CTRL] & mon_set[ism_pkg::MST_DATA_RX])
            begin
                rx_hs_r <= 1'b1;
            end
            else if (rd_mon_data | ~mctl_r[ism_pkg::MCTL_HS_CTRL] | ~mon_gen2)
            begin
                rx_hs_r <= 1'b0;
            end
        end
    end
    assign rx_handshake_bit = rx_hs_r;

    // monitor status flag: every byte in first-gen mode, state bits in second-gen
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mon_status_r <= 1'b0;
        end
        else if (pclken)
        begin
            if ((mon_byte & ~mon_gen2) | (|mon_set))
            begin
                mon_status_r <= 1'b1;
            end
            else if (rd_primary & prdata_r[ism_pkg::PRI_MON_STATUS])
            begin
                mon_status_r <= 1'b0;
            end
        end
    end

    // request pin moves only on a data-clock rising edge; a level, so it
    // never drops while any unmasked flag remains
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            dcl_q_r <= 1'b0;
            irq_oe_r <= 1'b0;
        end
        else if (pclken)
        begin
            dcl_q_r <= serial_data_clock;
            if (dcl_rise)
            begin
                irq_oe_r <= |primary_vis;
            end
        end
    end
    assign dcl_rise = serial_data_clock & ~dcl_q_r;

    // open drain: drive low while requesting, otherwise release
    assign irq_n_out = 1'b0;
    assign irq_n_oe = irq_oe_r;
endmodule
`default_nettype wire

/* ism_pkg.sv */
// shared constants and types for the interrupt status and mask logic
`default_nettype none
package ism_pkg;
    // register byte addresses
    localparam logic [7:0] ADDR_PRIMARY = 8'h00;
    localparam logic [7:0] ADDR_MASK = 8'h04;
    localparam logic [7:0] ADDR_EXTENDED = 8'h08;
    localparam logic [7:0] ADDR_CH0_CODE = 8'h0C;
    localparam logic [7:0] ADDR_CH1_CODE = 8'h10;
    localparam logic [7:0] ADDR_SQ_CODE = 8'h14;
    localparam logic [7:0] ADDR_SQ_TX = 8'h18;
    localparam logic [7:0] ADDR_MON_CTRL = 8'h1C;
    localparam logic [7:0] ADDR_MON_STATE = 8'h20;
    localparam logic [7:0] ADDR_MON_DATA = 8'h24;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int CODE_W = 4;
    localparam int NUM_CODE = 3;
    localparam int NUM_DIRECT = 5;
    localparam int NUM_EXT = 8;
    // code buffer channel indices
    localparam int CH_SQ = 0;
    localparam int CH_0 = 1;
    localparam int CH_1 = 2;
    // primary status fields
    localparam int PRI_EXT_SUMMARY = 0;
    localparam int PRI_MON_STATUS = 1;
    localparam int PRI_CODE_CHANGE = 2;
    localparam int PRI_DIRECT_LSB = 3;
    // ch0 code receive register fields
    localparam int CH0_CHG_LSB = 4;
    // sq transmit register fields
    localparam int SQTX_SQ_EN = 0;
    localparam int SQTX_CH1_EN = 1;
    // monitor control fields
    localparam int MCTL_RX_EN = 0;
    localparam int MCTL_HS_CTRL = 1;
    localparam int MCTL_TX_EN = 2;
    // monitor state fields
    localparam int MST_DATA_RX = 0;
    localparam int MST_END_RX = 1;
    localparam int MST_ACKED = 2;
    localparam int MST_ABORT = 3;
    // reset values
    localparam logic [7:0] MASK_RESET = 8'h00;
    localparam logic [1:0] SQTX_RESET = 2'h3;
    localparam logic [2:0] MCTL_RESET = 3'h0;
    // bus access phase
    typedef enum logic [1:0] {
        ISM_IDLE = 2'b00,
        ISM_WAIT = 2'b01,
        ISM_DONE = 2'b10
    } ism_bus_e;
endpackage
`default_nettype wire

/* ism_code_if.sv */
// connection between the top and one received-code buffer
`default_nettype none
interface ism_code_if;
    logic [ism_pkg::CODE_W-1:0] code_in;
    logic enable;
    logic rd;
    logic [ism_pkg::CODE_W-1:0] code_out;
    logic changed;
    modport owner (output code_in, output enable, output rd, input code_out, input changed);
    modport buffer (input code_in, input enable, input rd, output code_out, output changed);
endinterface
`default_nettype wire

/* ism_code_buf.sv */
// two-deep received-code buffer with change flag
`default_nettype none
module ism_code_buf (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic pclken,
    ism_code_if.buffer cb
);
    logic [ism_pkg::CODE_W-1:0] seen_r;
    logic [ism_pkg::CODE_W-1:0] code_r;
    logic [ism_pkg::CODE_W-1:0] code_nxt;
    logic [ism_pkg::CODE_W-1:0] pend_code_r;
    logic [ism_pkg::CODE_W-1:0] pend_code_nxt;
    logic unread_r;
    logic unread_nxt;
    logic pend_r;
    logic pend_nxt;
    logic chg;
    logic rd_eff;

    assign chg = (cb.code_in != seen_r);
    // a read while disabled must not discard the hidden change
    assign rd_eff = cb.rd & cb.enable;
    assign cb.code_out = code_r;
    assign cb.changed = unread_r & cb.enable;

    // read first, then a new change; a change in the read cycle is never lost
    always_comb
    begin
        code_nxt = code_r;
        pend_code_nxt = pend_code_r;
        unread_nxt = unread_r;
        pend_nxt = pend_r;
        if (rd_eff)
        begin
            if (pend_r)
            begin
                code_nxt = pend_code_r;
                pend_nxt = 1'b0;
            end
            else
            begin
                unread_nxt = 1'b0;
            end
        end
        if (chg)
        begin
            if (!unread_nxt)
            begin
                code_nxt = cb.code_in;
                unread_nxt = 1'b1;
            end
            else
            begin
                pend_code_nxt = cb.code_in;
                pend_nxt = 1'b1;
            end
        end
    end

    // buffer state
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            seen_r <= '0;
            code_r <= '0;
            pend_code_r <= '0;
            unread_r <= 1'b0;
            pend_r <= 1'b0;
        end
        else if (pclken)
        begin
            seen_r <= cb.code_in;
            code_r <= code_nxt;
            pend_code_r <= pend_code_nxt;
            unread_r <= unread_nxt;
            pend_r <= pend_nxt;
        end
    end
endmodule
`default_nettype wire

/* ism_top_monitor.sv */
// assertion checker watching the ports of the interrupt status and mask logic
`default_nettype none
module ism_top_monitor (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic serial_data_clock,
    input wire logic irq_n_out,
    input wire logic irq_n_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    logic dcl_q;
    logic acc_q;
    logic rise;
    logic [7:0] mask_q;
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // previous data-clock sample, for rising edge detection
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
            dcl_q <= 1'b0;
        else
            dcl_q <= serial_data_clock;
    assign rise = serial_data_clock & ~dcl_q;
    // shadow mask so read data can be judged without the body
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
            mask_q <= ism_pkg::MASK_RESET;
        else if (pready && pwrite && paddr == {24'h0, ism_pkg::ADDR_MASK})
            mask_q <= pwdata[7:0];
    // any completed access may clear a flag, so only quiet periods must hold the line
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
            acc_q <= 1'b0;
        else if (pready)
            acc_q <= 1'b1;
        else if (rise)
            acc_q <= 1'b0;
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_access;
        psel && penable;
    endsequence
    AST_ONE_WAIT: assert property (s_setup ##1 s_access |=> pready)
        else $error("no ready");
    AST_READY_PULSE: assert property (pready |=> !pready)
        else $error("ready held");
    AST_UNMAPPED: assert property (pready && paddr[7:0] > 8'h24 |-> pslverr && prdata == 32'h0)
        else $error("unmapped accepted");
    AST_OPEN_DRAIN: assert property (irq_n_out == 1'b0)
        else $error("pin driven high");
    AST_DCL_ONLY: assert property (!rise |=> $stable(irq_n_oe))
        else $error("request moved off edge");
    AST_NO_GAP: assert property (rise && !acc_q |=> !$fell(irq_n_oe))
        else $error("request gap");
    AST_MASK_ALL: assert property (mask_q == 8'hFF && rise |=> !irq_n_oe)
        else $error("request while all masked");
    AST_HIDDEN: assert property (pready && !pwrite && paddr == {24'h0, ism_pkg::ADDR_PRIMARY}
        |-> (prdata[7:0] & mask_q) == 8'h00)
        else $error("masked bit visible");
endmodule
bind ism_top ism_top_monitor ism_top_monitor_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .serial_data_clock(serial_data_clock), .irq_n_out(irq_n_out), .irq_n_oe(irq_n_oe));
`default_nettype wire

/* ism_host_model.sv */
// host side of the request pin: pull-up wire and an edge-triggered controller
`default_nettype none
module ism_host_model (
    input wire logic irq_n_out,
    input wire logic irq_n_oe,
    output logic irq_line,
    output int irq_edges
);
    timeunit 1ns;
    timeprecision 1ps;
    // pull-up on a released line
    assign irq_line = irq_n_oe ? irq_n_out : 1'b1;
    // counts falls only: a held low line is served once
    initial irq_edges = 0;
    always @(negedge irq_line)
        irq_edges++;
endmodule
`default_nettype wire

/* ism_top_bench.sv */
// self-checking testbench for the interrupt status and mask logic
`default_nettype none
module ism_top_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 1'b0, presetn = 1'b0, pclken = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata;
    logic pready, pslverr, rx_handshake_bit, irq_n_out, irq_n_oe, irq_line, berr;
    logic serial_data_clock = 1'b0, second_gen_mode = 1'b1, terminal_mode = 1'b1;
    logic [4:0] direct_evt = 5'h0;
    logic [7:0] ext_evt = 8'h0, monitor_data_in = 8'h0, q, r;
    logic [3:0] sq_code_in = 4'h0, ch0_code_in = 4'h0, ch1_code_in = 4'h0;
    logic tx_handshake_bit = 1'b1, monitor_first_byte = 1'b0;
    logic monitor_end_evt = 1'b0, monitor_ack_evt = 1'b0, monitor_abort_evt = 1'b0;
    logic [2:0] dcnt = 3'h0;
    int err_total = 0, n_checks = 0, cyc = 0, seed, k, irq_edges;
    ism_top ism_top_i (.pclk(pclk), .presetn(presetn), .pclken(pclken), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .serial_data_clock(serial_data_clock), .second_gen_mode(second_gen_mode), .terminal_mode(terminal_mode),
        .direct_evt(direct_evt), .ext_evt(ext_evt), .sq_code_in(sq_code_in), .ch0_code_in(ch0_code_in),
        .ch1_code_in(ch1_code_in), .tx_handshake_bit(tx_handshake_bit), .monitor_data_in(monitor_data_in),
        .monitor_first_byte(monitor_first_byte), .monitor_end_evt(monitor_end_evt),
        .monitor_ack_evt(monitor_ack_evt), .monitor_abort_evt(monitor_abort_evt),
        .rx_handshake_bit(rx_handshake_bit), .irq_n_out(irq_n_out), .irq_n_oe(irq_n_oe));
    ism_host_model ism_host_model_i (.irq_n_out(irq_n_out), .irq_n_oe(irq_n_oe), .irq_line(irq_line),
        .irq_edges(irq_edges));
    always #2.5 pclk = ~pclk;
    // data clock at an eighth of the bus rate, held low in reset
    always @(posedge pclk)
    begin
        dcnt <= dcnt + 3'h1;
        serial_data_clock <= presetn & dcnt[2];
    end
    // hang guard: the full run needs well under a thousand cycles
    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            err_total++;
            $display("MISMATCH t=%0t timeout", $time);
            results();
        end
    end
    function automatic logic [7:0] pexp(input logic [4:0] d);
        return {d, 3'b000};
    endfunction
    // f is {ch1, ch0, sq} changed
    function automatic logic [7:0] cexp(input logic [3:0] c, input logic [2:0] f);
        return {1'b0, f, c};
    endfunction
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        n_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("MISMATCH t=%0t bit %b exp %b", $time, got, exp);
        end
    endtask
    // one apb transfer; request held until ready is seen at an edge
    task automatic bus(input logic [7:0] a, input logic w, input logic [7:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {24'h0, a};
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 40);
        chk1(pready, 1'b1);
        q = prdata[7:0];
        berr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        bus(a, 1'b0, 8'h00);
        chk8(q, e);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus(a, 1'b1, d);
    endtask
    task automatic wait_irq(input logic e);
        int n;
        n = 0;
        while (irq_line !== e && n < 40)
        begin
            @(posedge pclk);
            n++;
        end
        chk1(irq_line, e);
    endtask
    task automatic hold_hi;
        logic lo;
        lo = 1'b0;
        repeat (24)
        begin
            @(posedge pclk);
            lo = lo | (irq_line !== 1'b1);
        end
        chk1(lo, 1'b0);
    endtask
    // m is {abort, ack, end}
    task automatic pulse(input logic [4:0] d, input logic [7:0] e, input logic [2:0] m);
        @(posedge pclk);
        direct_evt <= d;
        ext_evt <= e;
        {monitor_abort_evt, monitor_ack_evt, monitor_end_evt} <= m;
        @(posedge pclk);
        direct_evt <= 5'h0;
        ext_evt <= 8'h0;
        {monitor_abort_evt, monitor_ack_evt, monitor_end_evt} <= 3'h0;
    endtask
    task automatic mbyte(input logic [7:0] d, input logic f);
        @(posedge pclk);
        tx_handshake_bit <= 1'b1;
        monitor_data_in <= d;
        monitor_first_byte <= f;
        @(posedge pclk);
        tx_handshake_bit <= 1'b0;
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial
    begin
        seed = 24991;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        rd(8'h04, ism_pkg::MASK_RESET);
        rd(8'h18, {6'h0, ism_pkg::SQTX_RESET});
        rd(8'h1C, {5'h0, ism_pkg::MCTL_RESET});
        chk1(irq_line, 1'b1);
        $display("test reset done");
        for (int i = 0; i < 3; i++)
        begin
            r = 8'($random(seed)) | 8'h01;
            pulse(r[4:0], 8'h00, 3'h0);
            wait_irq(1'b0);
            rd(8'h00, pexp(r[4:0]));
            rd(8'h00, 8'h00);
            wait_irq(1'b1);
        end
        wr(8'h04, 8'hF8);
        pulse(5'h1F, 8'h00, 3'h0);
        hold_hi();
        rd(8'h00, 8'h00);
        wr(8'h04, 8'h00);
        wait_irq(1'b0);
        rd(8'h00, 8'hF8);
        wait_irq(1'b1);
        pulse(5'h02, 8'h00, 3'h0);
        wait_irq(1'b0);
        k = irq_edges;
        wr(8'h04, 8'hFF);
        wait_irq(1'b1);
        wr(8'h04, 8'h00);
        wait_irq(1'b0);
        chk8(8'(irq_edges - k), 8'h01);
        rd(8'h00, 8'h10);
        r = 8'($random(seed)) | 8'h80;
        pulse(5'h00, r, 3'h0);
        wait_irq(1'b0);
        rd(8'h00, 8'h01);
        rd(8'h00, 8'h01);
        rd(8'h08, r);
        rd(8'h00, 8'h00);
        wait_irq(1'b1);
        $display("test status done");
        ch0_code_in <= 4'h7;
        wait_irq(1'b0);
        rd(8'h00, 8'h04);
        rd(8'h00, 8'h04);
        rd(8'h0C, cexp(4'h7, 3'b010));
        rd(8'h0C, cexp(4'h7, 3'b000));
        ch0_code_in <= 4'hC;
        repeat (3) @(posedge pclk);
        ch0_code_in <= 4'h5;
        repeat (3) @(posedge pclk);
        ch0_code_in <= 4'h3;
        rd(8'h0C, cexp(4'hC, 3'b010));
        rd(8'h0C, cexp(4'h3, 3'b010));
        rd(8'h0C, cexp(4'h3, 3'b000));
        wait_irq(1'b1);
        wr(8'h04, 8'h04);
        sq_code_in <= 4'h9;
        hold_hi();
        wr(8'h04, 8'h00);
        rd(8'h0C, cexp(4'h3, 3'b001));
        wait_irq(1'b1);
        wr(8'h18, 8'h02);
        sq_code_in <= 4'hA;
        hold_hi();
        rd(8'h0C, cexp(4'h3, 3'b000));
        wr(8'h18, 8'h03);
        wait_irq(1'b0);
        rd(8'h0C, cexp(4'h3, 3'b001));
        sq_code_in <= 4'h2;
        ch1_code_in <= 4'h6;
        ch0_code_in <= 4'hE;
        wait_irq(1'b0);
        rd(8'h0C, cexp(4'hE, 3'b111));
        rd(8'h0C, cexp(4'hE, 3'b000));
        wait_irq(1'b1);
        terminal_mode <= 1'b0;
        ch1_code_in <= 4'h8;
        hold_hi();
        rd(8'h0C, cexp(4'hE, 3'b000));
        $display("test codes done");
        mbyte(8'hA5, 1'b1);
        rd(8'h20, 8'h00);
        wr(8'h1C, 8'h01);
        mbyte(8'h11, 1'b0);
        rd(8'h20, 8'h00);
        mbyte(8'h3C, 1'b1);
        rd(8'h20, 8'h01);
        wr(8'h1C, 8'h03);
        r = 8'($random(seed));
        mbyte(r, 1'b0);
        rd(8'h20, 8'h01);
        chk1(rx_handshake_bit, 1'b1);
        rd(8'h24, r);
        pulse(5'h00, 8'h00, 3'b110);
        rd(8'h20, 8'h00);
        chk1(rx_handshake_bit, 1'b0);
        wr(8'h1C, 8'h07);
        pulse(5'h00, 8'h00, 3'b111);
        rd(8'h20, 8'h0E);
        rd(8'h00, 8'h02);
        wait_irq(1'b1);
        second_gen_mode <= 1'b0;
        mbyte(8'h5A, 1'b0);
        wait_irq(1'b0);
        rd(8'h00, 8'h02);
        rd(8'h24, 8'h5A);
        wait_irq(1'b1);
        $display("test monitor done");
        bus(8'h28, 1'b0, 8'h00);
        chk1(berr, 1'b1);
        chk8(q, 8'h00);
        wr(8'h08, 8'hFF);
        chk1(berr, 1'b0);
        rd(8'h08, 8'h00);
        $display("test bus done");
        results();
    end
endmodule
`default_nettype wire
